// *** instr_timing_pkg.sv ***
// constants and types for the instruction length and cycle sequencer
package instr_timing_pkg;

    localparam int PC_W   = 16;
    localparam int BYTE_W = 8;
    localparam int LEN_W  = 2;
    localparam int CNT_W  = 4;

    localparam logic [CNT_W-1:0] CYC_MAX   = 4'h8;
    localparam logic [PC_W-1:0]  PC_STEP   = 16'h0001;
    localparam logic [PC_W-1:0]  DATA_POINTER_STEP = 16'h0001;
    localparam logic [LEN_W-1:0] LEN_ONE   = 2'h1;
    localparam logic [CNT_W-1:0] CNT_ONE   = 4'h1;

    localparam logic [BYTE_W-1:0] OP_LOAD_DATA_POINTER = 8'h90;
    localparam logic [BYTE_W-1:0] OP_INC_DATA_POINTER  = 8'ha3;

    typedef enum logic [1:0] {
        ST_OPCODE  = 2'b00,
        ST_OPERAND = 2'b01,
        ST_EXECUTE = 2'b10
    } phase_e;

    typedef struct packed {
        logic [LEN_W-1:0] len;
        logic [CNT_W-1:0] cyc;
        logic             cond;
        logic             rel;
        logic             xrd;
        logic             xwr;
        logic             xwide;
        logic             crd;
        logic             cpc;
    } dec_s;

    typedef struct packed {
        logic              start;
        logic              done;
        logic [BYTE_W-1:0] opcode;
        logic [BYTE_W-1:0] operand1;
        logic [BYTE_W-1:0] operand2;
        logic [LEN_W-1:0]  len;
        logic [CNT_W-1:0]  cycles;
    } instr_info_s;

    typedef struct packed {
        logic            xrd;
        logic            xwr;
        logic            to_flash;
        logic            code_rd;
        logic [PC_W-1:0] addr;
    } mem_req_s;

    typedef struct packed {
        phase_e            phase;
        logic [PC_W-1:0]   pc;
        logic [PC_W-1:0]   target;
        logic [PC_W-1:0]   data_pointer;
        logic              taken;
        logic [LEN_W-1:0]  bytes_left;
        logic [CNT_W-1:0]  cyc_left;
        dec_s              dec;
        instr_info_s       info;
        mem_req_s          mreq;
    } core_s;

    localparam core_s CORE_RESET = '0;

endpackage

// *** instr_cycle_seq.sv ***
// instruction length decode and clock-cycle sequencer of the core
`timescale 1ns/1ps
module instr_cycle_seq (
    input  wire logic                               core_clk,
    input  wire logic                               rst_n,
    input  wire logic                               clk_en,
    input  wire logic [instr_timing_pkg::BYTE_W-1:0] fetch_byte,
    input  wire logic                               branch_cond,
    input  wire logic                               jump_load,
    input  wire logic [instr_timing_pkg::PC_W-1:0]  jump_addr,
    input  wire logic [instr_timing_pkg::BYTE_W-1:0] acc_value,
    input  wire logic [instr_timing_pkg::BYTE_W-1:0] ptr_value,
    input  wire logic                               flash_wr_en,
    output logic [instr_timing_pkg::PC_W-1:0]       fetch_addr,
    output instr_timing_pkg::instr_info_s           info,
    output instr_timing_pkg::mem_req_s              mem_req
);
    import instr_timing_pkg::*;

    logic [1:0]        rst_sync_ff;
    logic              rst_core_n;
    core_s             st_ff;
    core_s             nxt_st;
    dec_s              dec_now;
    logic              fin;
    logic [CNT_W-1:0]  rem;
    logic [PC_W-1:0]   pc_adv;
    logic [PC_W-1:0]   rel_tgt;

    function automatic dec_s mk(input logic [LEN_W-1:0] len,
                                input logic [CNT_W-1:0] cyc,
                                input logic             cond);
        dec_s r;
        r       = '0;
        r.len   = len;
        r.cyc   = cyc;
        r.cond  = cond;
        r.rel   = cond;
        return r;
    endfunction

    // length and taken-path clock count from the opcode alone
    function automatic dec_s decode(input logic [BYTE_W-1:0] op);
        dec_s d;
        logic [3:0] hi;
        logic [3:0] lo;
        hi = op[7:4];
        lo = op[3:0];
        d  = mk(2'h1, 4'h1, 1'b0);
        if (lo[3]) begin
            case (hi)
                4'h7, 4'h8, 4'ha: d = mk(2'h2, 4'h2, 1'b0);
                4'hb:             d = mk(2'h3, 4'h4, 1'b1);
                4'hd:             d = mk(2'h2, 4'h3, 1'b1);
                default:          d = mk(2'h1, 4'h1, 1'b0);
            endcase
        end else if (lo[3:1] == 3'h3) begin
            case (hi)
                4'h7, 4'h8, 4'ha: d = mk(2'h2, 4'h2, 1'b0);
                4'hb:             d = mk(2'h3, 4'h5, 1'b1);
                default:          d = mk(2'h1, 4'h2, 1'b0);
            endcase
        end else if (lo == 4'h1) begin
            d = mk(2'h2, 4'h3, 1'b0);
        end else begin
            case (op)
                8'h10, 8'h20, 8'h30: d = mk(2'h3, 4'h4, 1'b1);
                8'h40, 8'h50, 8'h60, 8'h70: begin
                    d = mk(2'h2, 4'h3, 1'b1);
                end
                8'h80: begin
                    d     = mk(2'h2, 4'h3, 1'b0);
                    d.rel = 1'b1;
                end
                8'h90, 8'h75, 8'h85, 8'h43, 8'h53, 8'h63: begin
                    d = mk(2'h3, 4'h3, 1'b0);
                end
                8'h02, 8'h12: d = mk(2'h3, 4'h4, 1'b0);
                8'h22, 8'h32: d = mk(2'h1, 4'h5, 1'b0);
                8'h73:        d = mk(2'h1, 4'h3, 1'b0);
                8'h83, 8'h93: begin
                    d     = mk(2'h1, 4'h3, 1'b0);
                    d.crd = 1'b1;
                    d.cpc = ~op[4];
                end
                8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3: begin
                    d       = mk(2'h1, 4'h3, 1'b0);
                    d.xrd   = ~op[4];
                    d.xwr   = op[4];
                    d.xwide = ~op[1];
                end
                8'h84:        d = mk(2'h1, CYC_MAX, 1'b0);
                8'ha4:        d = mk(2'h1, 4'h4, 1'b0);
                8'hb4, 8'hb5, 8'hd5: d = mk(2'h3, 4'h4, 1'b1);
                8'h00, 8'h03, 8'h04, 8'h13, 8'h14, 8'h23, 8'h33,
                8'ha3, 8'ha5, 8'hb3, 8'hc3, 8'hc4, 8'hd3, 8'hd4,
                8'he4, 8'hf4: begin
                    d = mk(2'h1, 4'h1, 1'b0);
                end
                default: d = mk(2'h2, 4'h2, 1'b0);
            endcase
        end
        return d;
    endfunction

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_ff <= 2'b00;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end

    assign rst_core_n = rst_sync_ff[1];

    always_comb begin
        dec_now = decode(fetch_byte);
        nxt_st  = st_ff;
        fin     = 1'b0;
        rem     = st_ff.cyc_left;
        pc_adv  = st_ff.pc + PC_STEP;
        // signed offset from the byte after the instruction
        rel_tgt = pc_adv + {{(PC_W-BYTE_W){fetch_byte[BYTE_W-1]}}, fetch_byte};
        if (clk_en) begin
            nxt_st.info.start = 1'b0;
            nxt_st.info.done  = 1'b0;
            nxt_st.mreq       = '0;
            case (st_ff.phase)
                ST_OPCODE: begin
                    nxt_st.pc            = pc_adv;
                    nxt_st.dec           = dec_now;
                    nxt_st.taken         = 1'b0;
                    nxt_st.info.start    = 1'b1;
                    nxt_st.info.opcode   = fetch_byte;
                    nxt_st.info.operand1 = '0;
                    nxt_st.info.operand2 = '0;
                    nxt_st.info.len      = dec_now.len;
                    nxt_st.info.cycles   = dec_now.cyc;
                    rem = dec_now.cyc - CNT_ONE;
                    nxt_st.bytes_left = dec_now.len - LEN_ONE;
                    if (dec_now.len != LEN_ONE) begin
                        nxt_st.phase = ST_OPERAND;
                    end else if (rem == '0) begin
                        fin = 1'b1;
                    end else begin
                        nxt_st.phase = ST_EXECUTE;
                    end
                end
                ST_OPERAND: begin
                    nxt_st.pc = pc_adv;
                    if (st_ff.bytes_left == st_ff.dec.len - LEN_ONE) begin
                        nxt_st.info.operand1 = fetch_byte;
                    end else begin
                        nxt_st.info.operand2 = fetch_byte;
                    end
                    nxt_st.bytes_left = st_ff.bytes_left - LEN_ONE;
                    rem = st_ff.cyc_left - CNT_ONE;
                    if (st_ff.bytes_left == LEN_ONE) begin
                        nxt_st.target = rel_tgt;
                        nxt_st.taken  = st_ff.dec.rel &
                                        (~st_ff.dec.cond | branch_cond);
                        if (st_ff.dec.cond && !branch_cond) begin
                            rem = rem - CNT_ONE;
                        end
                        if (rem == '0) begin
                            fin = 1'b1;
                        end else begin
                            nxt_st.phase = ST_EXECUTE;
                        end
                    end
                end
                ST_EXECUTE: begin
                    rem = st_ff.cyc_left - CNT_ONE;
                    if (rem == '0) begin
                        fin = 1'b1;
                    end
                end
                default: begin
                    nxt_st.phase = ST_OPCODE;
                end
            endcase
            nxt_st.cyc_left = rem;
            if (fin) begin
                nxt_st.phase     = ST_OPCODE;
                nxt_st.info.done = 1'b1;
                if (nxt_st.taken) begin
                    nxt_st.pc = nxt_st.target;
                end else if (jump_load) begin
                    nxt_st.pc = jump_addr;
                end
                if (nxt_st.info.opcode == OP_LOAD_DATA_POINTER) begin
                    nxt_st.data_pointer = {nxt_st.info.operand1,
                                   nxt_st.info.operand2};
                end else if (nxt_st.info.opcode == OP_INC_DATA_POINTER) begin
                    nxt_st.data_pointer = st_ff.data_pointer + DATA_POINTER_STEP;
                end
                // on-chip only: ram space, or program flash for writes when enabled
                nxt_st.mreq.xrd      = nxt_st.dec.xrd;
                nxt_st.mreq.xwr      = nxt_st.dec.xwr;
                nxt_st.mreq.to_flash = nxt_st.dec.xwr & flash_wr_en;
                nxt_st.mreq.code_rd  = nxt_st.dec.crd;
                if (nxt_st.dec.crd) begin
                    nxt_st.mreq.addr = (nxt_st.dec.cpc ? nxt_st.pc : st_ff.data_pointer)
                                       + {{(PC_W-BYTE_W){1'b0}}, acc_value};
                end else if (nxt_st.dec.xwide) begin
                    nxt_st.mreq.addr = st_ff.data_pointer;
                end else begin
                    nxt_st.mreq.addr = {{(PC_W-BYTE_W){1'b0}}, ptr_value};
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            st_ff <= CORE_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign fetch_addr = st_ff.pc;
    assign info       = st_ff.info;
    assign mem_req    = st_ff.mreq;

endmodule

// *** prog_mem.sv ***
// combinational program memory answering the sequencer's fetches
`timescale 1ns/1ps
module prog_mem (
    input  wire logic [instr_timing_pkg::PC_W-1:0]   addr,
    output logic      [instr_timing_pkg::BYTE_W-1:0] data
);
    import instr_timing_pkg::*;
    logic [BYTE_W-1:0] mem [0:255];
    // byte at the fetch address in the same cycle
    assign data = mem[addr[7:0]];
endmodule

// *** instr_timing_monitor.sv ***
// concurrent checks on the cycle sequencer ports
`timescale 1ns/1ps
module instr_timing_monitor (
    input wire logic                  core_clk,
    input wire logic                  rst_n,
    input wire logic                  branch_cond,
    input wire logic                  flash_wr_en,
    input wire logic [15:0]           fetch_addr,
    input instr_timing_pkg::instr_info_s info,
    input instr_timing_pkg::mem_req_s    mem_req
);
    import instr_timing_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic cnd;
    assign cnd = (info.opcode == 8'h60) || (info.opcode == 8'h70);

    property p_bound;
        info.start |-> info.cycles != 4'h0 && info.cycles <= CYC_MAX;
    endproperty
    a_bound: assert property (p_bound)
        else $error("instruction clock count out of range");
    property p_one;
        info.start && info.cycles == 4'h1 |-> info.done;
    endproperty
    a_one: assert property (p_one)
        else $error("one clock instruction did not end at once");
    property p_two;
        info.start && info.cycles == 4'h2 |-> !info.done ##1 info.done;
    endproperty
    a_two: assert property (p_two)
        else $error("two clock instruction ended at wrong time");
    property p_three;
        info.start && info.cycles == 4'h3 && info.len != 2'h2
            |-> !info.done [*2] ##1 info.done;
    endproperty
    a_three: assert property (p_three)
        else $error("three clock instruction ended at wrong time");
    property p_not_taken;
        info.start && cnd && !branch_cond |-> ##1 info.done;
    endproperty
    a_not_taken: assert property (p_not_taken)
        else $error("branch not taken did not end one clock early");
    property p_taken;
        info.start && cnd && branch_cond |-> ##1 !info.done ##1 info.done;
    endproperty
    a_taken: assert property (p_taken)
        else $error("taken branch did not take three clocks");
    property p_xwr;
        info.start && info.opcode == 8'hf0 |-> ##2 info.done && mem_req.xwr
            && mem_req.to_flash == $past(flash_wr_en);
    endproperty
    a_xwr: assert property (p_xwr)
        else $error("external write pulse or flash target wrong");
    property p_xrd;
        info.start && info.opcode == 8'he0 |-> ##2 mem_req.xrd && !mem_req.xwr;
    endproperty
    a_xrd: assert property (p_xrd)
        else $error("external read pulse missing");
    property p_crd;
        info.start && info.opcode == 8'h93
            |-> ##2 mem_req.code_rd && !mem_req.xrd;
    endproperty
    a_crd: assert property (p_crd)
        else $error("code read pulse missing");
    property p_fetch;
        info.start |-> fetch_addr == $past(fetch_addr) + PC_STEP;
    endproperty
    a_fetch: assert property (p_fetch)
        else $error("operand not fetched right after opcode");
endmodule

// *** test_instruction_cycle_timing.sv ***
// self-checking bench for the instruction cycle sequencer
`timescale 1ns/1ps
module test_instruction_cycle_timing;
    import instr_timing_pkg::*;
    logic              core_clk;
    logic              rst_n;
    logic              branch_cond;
    logic              flash_wr_en;
    logic [PC_W-1:0]   fetch_addr;
    logic [BYTE_W-1:0] fetch_byte;
    logic [BYTE_W-1:0] acc_value;
    logic [BYTE_W-1:0] ptr_value;
    logic [1:0]        wr_kind;
    instr_info_s       info;
    mem_req_s          mem_req;
    int                n_errors;
    int                cmp_count;
    int                p;
    // entries are opcode, byte count, clock count
    logic [15:0] tbl [$] = '{16'h2811, 16'h2612, 16'h2522, 16'h2422,
        16'h3811, 16'h3522, 16'h9811, 16'h9612, 16'h5811, 16'h4811, 16'h6811,
        16'h5333, 16'h4333, 16'h6333, 16'h5222, 16'h0612, 16'h1612, 16'h0411,
        16'he411, 16'hf411, 16'h2311, 16'h3311, 16'h0311, 16'h1311, 16'hc411,
        16'hd411, 16'h7533, 16'h8533, 16'hf612, 16'ha622, 16'h7622, 16'hc022,
        16'hd022, 16'hc811, 16'hc522, 16'hc612, 16'hd612, 16'he213, 16'hf213,
        16'h9313, 16'h8313, 16'ha414, 16'h8418};
    logic [7:0] tail [$] = '{8'h90, 8'h12, 8'h34, 8'hf0, 8'hf0, 8'he0,
        8'he2, 8'h93, 8'h60, 8'h02, 8'h00, 8'h00, 8'h70, 8'hfe, 8'h60,
        8'h05};

    assign wr_kind = {mem_req.xwr, mem_req.to_flash};

    instr_cycle_seq u_instr_cycle_seq (.core_clk(core_clk), .rst_n(rst_n),
        .clk_en(1'b1), .fetch_byte(fetch_byte), .branch_cond(branch_cond),
        .jump_load(1'b0), .jump_addr(16'h0000), .acc_value(acc_value),
        .ptr_value(ptr_value), .flash_wr_en(flash_wr_en),
        .fetch_addr(fetch_addr), .info(info), .mem_req(mem_req));
    prog_mem u_prog_mem (.addr(fetch_addr), .data(fetch_byte));

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // waits for one instruction and measures start to done in clocks
    task automatic run_one(input logic [7:0] op, input logic [1:0] len,
                           input logic [3:0] cyc, input logic [3:0] dur);
        int k;
        k = 0;
        do begin
            @(negedge core_clk);
            k++;
        end while (info.start !== 1'b1 && k < 20);
        chk("opcode", {8'h00, op}, {8'h00, info.opcode});
        chk("length", {14'h0000, len}, {14'h0000, info.len});
        chk("cycles", {12'h000, cyc}, {12'h000, info.cycles});
        k = 1;
        while (info.done !== 1'b1 && k < 12) begin
            @(negedge core_clk);
            k++;
        end
        chk("duration", {12'h000, dur}, 16'(k));
    endtask

    task automatic t_table;
        logic [15:0] e;
        foreach (tbl[i]) begin
            e = tbl[i];
            run_one(e[15:8], e[5:4], e[3:0], e[3:0]);
        end
    endtask

    task automatic t_xmove;
        run_one(8'h90, 2'h3, 4'h3, 4'h3);
        chk("operands", 16'h1234, {info.operand1, info.operand2});
        flash_wr_en = 1'b1;
        run_one(8'hf0, 2'h1, 4'h3, 4'h3);
        chk("flash write", 16'h0003, 16'(wr_kind));
        chk("write address", 16'h1234, mem_req.addr);
        flash_wr_en = 1'b0;
        run_one(8'hf0, 2'h1, 4'h3, 4'h3);
        chk("ram write", 16'h0002, 16'(wr_kind));
        run_one(8'he0, 2'h1, 4'h3, 4'h3);
        chk("ram read", 16'h0001, {15'h0000, mem_req.xrd});
        run_one(8'he2, 2'h1, 4'h3, 4'h3);
        chk("pointer address", 16'h005a, mem_req.addr);
        run_one(8'h93, 2'h1, 4'h3, 4'h3);
        chk("code address", 16'h123b, mem_req.addr);
    endtask

    task automatic t_branch;
        branch_cond = 1'b1;
        run_one(8'h60, 2'h2, 4'h3, 4'h3);
        chk("forward target", 16'(p + 12), fetch_addr);
        run_one(8'h70, 2'h2, 4'h3, 4'h3);
        chk("backward target", 16'(p + 12), fetch_addr);
        branch_cond = 1'b0;
        run_one(8'h70, 2'h2, 4'h3, 4'h2);
        chk("fall through", 16'(p + 14), fetch_addr);
        run_one(8'h60, 2'h2, 4'h3, 4'h2);
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    initial begin
        #40000;
        n_errors++;
        end_of_test;
    end

    initial begin
        rst_n = 1'b0;
        branch_cond = 1'b0;
        flash_wr_en = 1'b0;
        acc_value = 8'h07;
        ptr_value = 8'h5a;
        n_errors = 0;
        cmp_count = 0;
        for (int i = 0; i < 256; i++) u_prog_mem.mem[i] = 8'h00;
        p = 0;
        foreach (tbl[i]) begin
            u_prog_mem.mem[p] = tbl[i][15:8];
            p = p + int'(tbl[i][7:4]);
        end
        foreach (tail[i]) u_prog_mem.mem[p + i] = tail[i];
        repeat (16) @(negedge core_clk);
        rst_n = 1'b1;
        t_table;
        t_xmove;
        t_branch;
        end_of_test;
    end
endmodule

bind instr_cycle_seq instr_timing_monitor u_instr_timing_monitor (
    .core_clk(core_clk), .rst_n(rst_n), .branch_cond(branch_cond),
    .flash_wr_en(flash_wr_en), .fetch_addr(fetch_addr), .info(info),
    .mem_req(mem_req));
